// ### design/ccs_pkg.sv
// package for the clock synthesis control block
package ccs_pkg;

  // register offsets
  localparam logic [7:0] CCS_ADDR_PLL_CTRL = 8'h00;
  localparam logic [7:0] CCS_ADDR_OSC_CTRL = 8'h04;
  localparam logic [7:0] CCS_ADDR_FOPT1    = 8'h08;
  localparam logic [7:0] CCS_ADDR_STATUS   = 8'h0c;

  // pll and postscaler figures
  localparam int          CCS_PLL_MULT       = 8;
  localparam int          CCS_PLL_MULT_LOG2  = $clog2(CCS_PLL_MULT);
  localparam int          CCS_HALF_SHIFT     = CCS_PLL_MULT_LOG2 + 1;
  localparam logic [2:0]  CCS_POST_MAX_CODE  = 3'h5;
  localparam int          CCS_TRIM_W         = 10;
  localparam int          CCS_TRIM_STEP_PPM  = 780;
  localparam int          CCS_OSC_NOM_KHZ    = 8000;
  localparam int          CCS_PER_W          = 16;
  localparam int          CCS_HALF_W         = CCS_PER_W + 5;
  localparam logic [15:0] CCS_PER_MAX        = 16'hffff;
  localparam logic [15:0] CCS_RDATA_NONE     = 16'h0000;
  localparam int          CCS_POST_CODES     = 6;
  localparam int          CCS_POST_W         = 3;
  localparam int          CCS_MODE_W         = 2;
  localparam int          CCS_STAT_PER_W     = 13;

  // pll_control_word bit positions
  localparam int          CCS_CTRL_SRC_BIT   = 0;
  localparam int          CCS_CTRL_POST_LSB  = 1;
  localparam int          CCS_CTRL_PLL_BIT   = 4;
  localparam int          CCS_CTRL_PIN_BIT   = 5;
  localparam int          CCS_CTRL_SEC_BIT   = 6;
  localparam int          CCS_CTRL_CRYS_BIT  = 7;
  localparam int          CCS_CTRL_MODE_LSB  = 8;

  // status word bit positions
  localparam int          CCS_STAT_EXT_BIT   = 15;
  localparam int          CCS_STAT_PLL_BIT   = 14;
  localparam int          CCS_STAT_LOCK_BIT  = 13;

  // relaxation oscillator power states
  typedef enum logic [1:0] {
    CCS_OSC_RUN     = 2'b00,
    CCS_OSC_STANDBY = 2'b01,
    CCS_OSC_DOWN    = 2'b10
  } ccs_osc_mode_t;

  // pll_control_word layout
  typedef struct packed {
    ccs_osc_mode_t osc_mode;
    logic          crys_pd;
    logic          ext_pin_sec;
    logic          ext_is_pin;
    logic          pll_en;
    logic [2:0]    post_code;
    logic          src_ext;
  } ccs_ctrl_t;

  localparam ccs_ctrl_t CCS_CTRL_RST = '{CCS_OSC_RUN, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0};

  // whole block state
  typedef struct packed {
    ccs_ctrl_t                ctrl;
    logic [CCS_TRIM_W-1:0]    trim;
    logic [CCS_TRIM_W-1:0]    fopt;
    logic                     fopt_ld;
    logic                     ref_prev;
    logic [CCS_PER_W-1:0]     per_cnt;
    logic [CCS_PER_W-1:0]     period;
    logic [CCS_HALF_W-1:0]    half_cnt;
    logic                     pll_clk;
    logic                     act_ext;
    logic                     act_pll;
    logic                     out2x;
    logic                     sys;
    logic [15:0]              rdata;
  } ccs_state_t;

endpackage

// ### design/ccs_clock_synthesis_control.sv
// clock synthesis control: reference select, pll model, postscaler, trim and power states
`timescale 1ns/1ns
module ccs_clock_synthesis_control
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // register port
  input  wire logic [7:0]            addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [15:0]           rdata,
  // reference inputs
  input  wire logic                  internal_osc_clk,
  input  wire logic                  crystal_sense_pin,
  input  wire logic                  external_reference_pin_pri,
  input  wire logic                  external_reference_pin_sec,
  input  wire logic [CCS_TRIM_W-1:0] factory_trim,
  // clocks out
  output logic                       clk2x_out,
  output logic                       sys_clk_out,
  // analog controls
  output logic      [CCS_TRIM_W-1:0] osc_trim,
  output logic                       osc_standby,
  output logic                       osc_powerdown,
  output logic                       crystal_powerdown,
  output logic                       pll_powerdown
);

  // registered state and its next value
  ccs_state_t s_q;
  ccs_state_t s_d;

  // reference selection
  logic                  ref_int;
  logic                  ref_pin;
  logic                  ref_crys;
  logic                  ref_ext;
  logic                  ref_cand;
  logic                  ref_act;
  logic                  ref_rise;
  logic                  ref_switch;

  // pll model
  logic [CCS_POST_W-1:0] post;
  logic [CCS_HALF_W-1:0] half_len;
  logic [CCS_HALF_W-1:0] half_inc;
  logic                  pll_run;
  logic                  pll_flip;
  logic [CCS_HALF_W-1:0] half_tab [CCS_POST_CODES];

  // output switch
  logic                  cur_clk;
  logic                  tgt_clk;
  logic                  sw_ok;
  logic                  out_rise;

  // register port
  logic [15:0]           rd_ctrl;
  logic [15:0]           rd_stat;
  logic [15:0]           rd_word;

  // half period of the pll output for each postscaler code
  genvar g;
  generate
    for (g = 0; g < CCS_POST_CODES; g++) begin : g_half
      assign half_tab[g] = (CCS_HALF_W'(s_q.period) << g) >> CCS_HALF_SHIFT;
    end
  endgenerate

  // control word readback, field by field
  always_comb begin
    rd_ctrl                                  = CCS_RDATA_NONE;
    rd_ctrl[CCS_CTRL_SRC_BIT]                = s_q.ctrl.src_ext;
    rd_ctrl[CCS_CTRL_POST_LSB +: CCS_POST_W] = s_q.ctrl.post_code;
    rd_ctrl[CCS_CTRL_PLL_BIT]                = s_q.ctrl.pll_en;
    rd_ctrl[CCS_CTRL_PIN_BIT]                = s_q.ctrl.ext_is_pin;
    rd_ctrl[CCS_CTRL_SEC_BIT]                = s_q.ctrl.ext_pin_sec;
    rd_ctrl[CCS_CTRL_CRYS_BIT]               = s_q.ctrl.crys_pd;
    rd_ctrl[CCS_CTRL_MODE_LSB +: CCS_MODE_W] = s_q.ctrl.osc_mode;
  end

  // status word readback
  always_comb begin
    rd_stat                        = CCS_RDATA_NONE;
    rd_stat[CCS_STAT_EXT_BIT]      = s_q.act_ext;
    rd_stat[CCS_STAT_PLL_BIT]      = s_q.act_pll;
    rd_stat[CCS_STAT_LOCK_BIT]     = (s_q.period != '0);
    rd_stat[CCS_STAT_PER_W-1:0]    = s_q.period[CCS_STAT_PER_W-1:0];
  end

  // next state
  always_comb begin
    s_d = s_q;

    // relaxation oscillator gated by its power state
    if (s_q.ctrl.osc_mode == CCS_OSC_DOWN) begin
      ref_int = 1'b0;
    end else begin
      ref_int = internal_osc_clk;
    end

    // external pin, primary or secondary
    if (s_q.ctrl.ext_pin_sec) begin
      ref_pin = external_reference_pin_sec;
    end else begin
      ref_pin = external_reference_pin_pri;
    end

    // crystal oscillator gated by its power control
    if (s_q.ctrl.crys_pd) begin
      ref_crys = 1'b0;
    end else begin
      ref_crys = crystal_sense_pin;
    end

    // external reference: crystal or pin
    if (s_q.ctrl.ext_is_pin) begin
      ref_ext = ref_pin;
    end else begin
      ref_ext = ref_crys;
    end

    // requested reference
    if (s_q.ctrl.src_ext) begin
      ref_cand = ref_ext;
    end else begin
      ref_cand = ref_int;
    end

    // applied reference, follows the request only through the switch
    if (s_q.act_ext) begin
      ref_act = ref_ext;
    end else begin
      ref_act = ref_int;
    end

    // reference period measurement in clk cycles
    if (ref_act && !s_q.ref_prev) begin
      ref_rise = 1'b1;
    end else begin
      ref_rise = 1'b0;
    end
    s_d.ref_prev = ref_act;
    if (ref_rise) begin
      // a saturated count marks a partial or missing period and is dropped,
      // so a fresh reference never hands the pll a short bogus period
      if (s_q.per_cnt != CCS_PER_MAX) begin
        s_d.period = s_q.per_cnt + CCS_PER_W'(1);
      end
      s_d.per_cnt = '0;
    end else if (s_q.per_cnt != CCS_PER_MAX) begin
      s_d.per_cnt = s_q.per_cnt + CCS_PER_W'(1);
    end

    // postscaler codes above the largest divide act as divide by 32
    if (s_q.ctrl.post_code > CCS_POST_MAX_CODE) begin
      post = CCS_POST_MAX_CODE;
    end else begin
      post = s_q.ctrl.post_code;
    end

    // pll half period of period * postscaler / 16, at least one cycle
    half_len = half_tab[post];
    if (half_len == '0) begin
      half_len = CCS_HALF_W'(1);
    end
    half_inc = s_q.half_cnt + CCS_HALF_W'(1);

    // the pll keeps running until the output switch has left it,
    // otherwise turning it off would cut a high phase short
    if ((s_q.ctrl.pll_en || s_q.act_pll) && (s_q.period != '0)) begin
      pll_run = 1'b1;
    end else begin
      pll_run = 1'b0;
    end
    if (half_inc >= half_len) begin
      pll_flip = 1'b1;
    end else begin
      pll_flip = 1'b0;
    end
    if (!pll_run) begin
      s_d.pll_clk  = 1'b0;
      s_d.half_cnt = '0;
    end else if (pll_flip) begin
      s_d.pll_clk  = ~s_q.pll_clk;
      s_d.half_cnt = '0;
    end else begin
      s_d.half_cnt = half_inc;
    end

    // glitch-free output switch: change only while old, new and output are low
    if (s_q.act_pll) begin
      cur_clk = s_q.pll_clk;
    end else begin
      cur_clk = ref_act;
    end
    if (s_q.ctrl.pll_en) begin
      tgt_clk = s_q.pll_clk;
    end else begin
      tgt_clk = ref_cand;
    end
    if (!s_q.out2x && !cur_clk && !tgt_clk) begin
      sw_ok = 1'b1;
    end else begin
      sw_ok = 1'b0;
    end
    if (sw_ok && (s_q.act_ext != s_q.ctrl.src_ext)) begin
      ref_switch = 1'b1;
    end else begin
      ref_switch = 1'b0;
    end
    if (sw_ok) begin
      s_d.act_ext = s_q.ctrl.src_ext;
      s_d.act_pll = s_q.ctrl.pll_en;
    end

    // a new reference restarts the period measurement
    if (ref_switch) begin
      s_d.per_cnt = CCS_PER_MAX;
    end

    // double-rate output, one cycle behind the selected clock
    s_d.out2x = cur_clk;
    if (cur_clk && !s_q.out2x) begin
      out_rise = 1'b1;
    end else begin
      out_rise = 1'b0;
    end

    // system integration unit halves the double-rate clock
    if (out_rise) begin
      s_d.sys = ~s_q.sys;
    end

    // factory trim copied once after reset release
    if (!s_q.fopt_ld) begin
      s_d.fopt    = factory_trim;
      s_d.fopt_ld = 1'b1;
    end

    // register writes; option word one and status are read only
    if (wr_en) begin
      case (addr)
        CCS_ADDR_PLL_CTRL: begin
          s_d.ctrl.src_ext     = wdata[CCS_CTRL_SRC_BIT];
          s_d.ctrl.post_code   = wdata[CCS_CTRL_POST_LSB +: CCS_POST_W];
          s_d.ctrl.pll_en      = wdata[CCS_CTRL_PLL_BIT];
          s_d.ctrl.ext_is_pin  = wdata[CCS_CTRL_PIN_BIT];
          s_d.ctrl.ext_pin_sec = wdata[CCS_CTRL_SEC_BIT];
          s_d.ctrl.crys_pd     = wdata[CCS_CTRL_CRYS_BIT];
          s_d.ctrl.osc_mode    = ccs_osc_mode_t'(wdata[CCS_CTRL_MODE_LSB +: CCS_MODE_W]);
        end
        CCS_ADDR_OSC_CTRL: begin
          s_d.trim = wdata[CCS_TRIM_W-1:0];
        end
        default: begin
          s_d.trim = s_q.trim;
        end
      endcase
    end

    // register reads, data valid in the following cycle only
    rd_word = CCS_RDATA_NONE;
    if (rd_en) begin
      case (addr)
        CCS_ADDR_PLL_CTRL: begin
          rd_word = rd_ctrl;
        end
        CCS_ADDR_OSC_CTRL: begin
          rd_word = 16'(s_q.trim);
        end
        CCS_ADDR_FOPT1: begin
          rd_word = 16'(s_q.fopt);
        end
        CCS_ADDR_STATUS: begin
          rd_word = rd_stat;
        end
        default: begin
          rd_word = CCS_RDATA_NONE;
        end
      endcase
    end
    s_d.rdata = rd_word;
  end

  // asynchronous reset to the boot state; the period counter starts saturated
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q.ctrl     <= CCS_CTRL_RST;
      s_q.trim     <= '0;
      s_q.fopt     <= '0;
      s_q.fopt_ld  <= 1'b0;
      s_q.ref_prev <= 1'b0;
      s_q.per_cnt  <= CCS_PER_MAX;
      s_q.period   <= '0;
      s_q.half_cnt <= '0;
      s_q.pll_clk  <= 1'b0;
      s_q.act_ext  <= 1'b0;
      s_q.act_pll  <= 1'b0;
      s_q.out2x    <= 1'b0;
      s_q.sys      <= 1'b0;
      s_q.rdata    <= CCS_RDATA_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs from the state flip-flops; osc_standby and osc_powerdown decoded, pll_powerdown inverted
  assign rdata             = s_q.rdata;
  assign clk2x_out         = s_q.out2x;
  assign sys_clk_out       = s_q.sys;
  // trim step of about 780 ppm of the 8 MHz nominal rate per count
  assign osc_trim          = s_q.trim;
  assign osc_standby       = (s_q.ctrl.osc_mode == CCS_OSC_STANDBY);
  assign osc_powerdown     = (s_q.ctrl.osc_mode == CCS_OSC_DOWN);
  assign crystal_powerdown = s_q.ctrl.crys_pd;
  assign pll_powerdown     = ~s_q.ctrl.pll_en;

endmodule

// ### test/ccs_properties.sv
// checker on the clock synthesis control ports
`timescale 1ns/1ns
module ccs_props
  import ccs_pkg::*;
(
  // watched ports
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic        clk2x_out,
  input wire logic        sys_clk_out,
  input wire logic        osc_standby,
  input wire logic        osc_powerdown,
  input wire logic        pll_powerdown,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic [9:0]  osc_trim,
  input wire logic [9:0]  factory_trim
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_sys_halves: assert property ($rose(clk2x_out) |-> sys_clk_out != $past(sys_clk_out))
    else $error("sys clock missed a toggle");
  a_sys_steady: assert property (!$rose(clk2x_out) |-> $stable(sys_clk_out))
    else $error("sys clock extra toggle");
  a_no_runt: assert property ($rose(clk2x_out) |=> clk2x_out [*2])
    else $error("runt pulse on 2x clock");
  a_trim_write: assert property (wr_en && addr == CCS_ADDR_OSC_CTRL |=> osc_trim == 10'($past(wdata)))
    else $error("trim not written");
  a_trim_read: assert property (rd_en && addr == CCS_ADDR_OSC_CTRL |=> rdata == {6'h00, osc_trim})
    else $error("trim readback wrong");
  a_fopt_read: assert property (rd_en && addr == CCS_ADDR_FOPT1 |=> rdata == {6'h00, factory_trim})
    else $error("factory trim readback wrong");
  a_pll_power: assert property (wr_en && addr == CCS_ADDR_PLL_CTRL |=>
    pll_powerdown == (($past(wdata) & 16'h0010) == 16'h0000)) else $error("pll power wrong");
  a_osc_modes: assert property (wr_en && addr == CCS_ADDR_PLL_CTRL |=>
    osc_standby == (($past(wdata) & 16'h0300) == 16'h0100) &&
    osc_powerdown == (($past(wdata) & 16'h0300) == 16'h0200)) else $error("osc mode wrong");
endmodule

// ### test/ccs_ref_src.sv
// reference sources: relaxation osc, crystal, two external pins, factory trim
`timescale 1ns/1ns
module ccs_ref_src
  import ccs_pkg::*;
#(
  parameter logic [9:0] FTRIM = 10'h2a5 // arbitrary calibration value
)(
  // power controls
  input  wire logic       osc_powerdown,
  input  wire logic       crystal_powerdown,
  // reference clocks and trim
  output logic            osc_clk,
  output logic            crystal_clk,
  output logic            pin_pri,
  output logic            pin_sec,
  output logic      [9:0] ftrim
);
  logic o = 1'b0, x = 1'b0, p = 1'b0, s = 1'b0;
  always #128 o = !o;
  always #64 x = !x;
  always #96 p = !p;
  always #192 s = !s;
  assign osc_clk = o & !osc_powerdown;
  assign crystal_clk = x & !crystal_powerdown;
  assign pin_pri = p;
  assign pin_sec = s;
  assign ftrim = FTRIM;
endmodule

// ### test/tb.sv
// testbench for the clock synthesis control block
`timescale 1ns/1ns
bind ccs_clock_synthesis_control ccs_props i_ccs_props (.clk(clk), .rstn(rstn), .wr_en(wr_en),
  .rd_en(rd_en), .clk2x_out(clk2x_out), .sys_clk_out(sys_clk_out), .osc_standby(osc_standby),
  .osc_powerdown(osc_powerdown), .pll_powerdown(pll_powerdown), .addr(addr), .wdata(wdata),
  .rdata(rdata), .osc_trim(osc_trim), .factory_trim(factory_trim));
module tb;
  import ccs_pkg::*;
  logic clk = 0, rstn = 0, wr_en = 0, rd_en = 0, p2 = 0, ps = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic osc, crys, pri, sec, c2x, sys, stby, opd, xpd, ppd;
  logic [9:0] trim, ftrim;
  int miscompares = 0, cmp_count = 0, n2 = 0, ns = 0, cyc = 0;
  always #2 clk = !clk;
  ccs_clock_synthesis_control i_ccs_clock_synthesis_control (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .internal_osc_clk(osc), .crystal_sense_pin(crys), .external_reference_pin_pri(pri),
    .external_reference_pin_sec(sec), .factory_trim(ftrim), .clk2x_out(c2x), .sys_clk_out(sys),
    .osc_trim(trim), .osc_standby(stby), .osc_powerdown(opd), .crystal_powerdown(xpd),
    .pll_powerdown(ppd));
  ccs_ref_src i_ccs_ref_src (.osc_powerdown(opd), .crystal_powerdown(xpd), .osc_clk(osc),
    .crystal_clk(crys), .pin_pri(pri), .pin_sec(sec), .ftrim(ftrim));
  always @(posedge clk) begin
    p2 <= c2x;
    ps <= sys;
    n2 <= n2 + int'(c2x & !p2);
    ns <= ns + int'(sys & !ps);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic meas(input logic [15:0] c, input int n);
    int a, b;
    wr(CCS_ADDR_PLL_CTRL, c);
    repeat (300) @(posedge clk);
    a = n2;
    b = ns;
    repeat (768) @(posedge clk);
    a = n2 - a;
    b = ns - b;
    if (a == n - 1 || a == n + 1) a = n;
    if (b == n / 2 - 1 || b == n / 2 + 1) b = n / 2;
    chk(16'(a), 16'(n));
    chk(16'(b), 16'(n / 2));
    rd(CCS_ADDR_STATUS);
    chk(v & 16'he000, {c[0], c[4], 1'b1, 13'h0000});
  endtask
  task automatic t_boot;
    rd(CCS_ADDR_PLL_CTRL);
    chk(v, 16'h0000);
    chk({15'h0000, ppd}, 16'h0001);
    wr(CCS_ADDR_FOPT1, 16'h0000);
    rd(CCS_ADDR_FOPT1);
    chk(v, {6'h00, ftrim});
    wr(CCS_ADDR_OSC_CTRL, v);
    #1 chk({6'h00, trim}, {6'h00, ftrim});
    @(posedge clk);
    wr(CCS_ADDR_OSC_CTRL, 16'hffff);
    rd(CCS_ADDR_OSC_CTRL);
    chk(v, 16'h03ff);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 3; m++) begin
      wr(CCS_ADDR_PLL_CTRL, 16'(m) << 8);
      #1 chk({14'h0000, stby, opd}, {14'h0000, m == 1, m == 2});
      @(posedge clk);
    end
    wr(CCS_ADDR_PLL_CTRL, 16'h0080);
    #1 chk({15'h0000, xpd}, 16'h0001);
    @(posedge clk);
  endtask
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_boot();
    t_modes();
    meas(16'h0000, 12);
    meas(16'h0001, 24);
    meas(16'h0021, 16);
    meas(16'h0061, 8);
    for (int c = 0; c < 8; c++) meas(16'h0010 | 16'(c << 1), 96 >> (c > 5 ? 5 : c));
    final_report();
  end
endmodule
